/* File: ccdc_defines.svh */
// Purpose: Offsets, field positions and reset values of the calculator core debug control.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Included by the top module and the bench.
// Functional notes
// - Core is halted, running or animated
// - Register writes accepted only while halted
// - Running executes instructions back to back
// - Animate pauses after each instruction for reporting
// - Reset outside init halts and loads program counter zero
// - Memory init fills all words with fill
// - Single step executes one instruction, halts
// - Step over runs whole called subroutine
// - Step over clears local cycle counter first
// - Step out clears counter, runs to return
// - Address breakpoint halts on 12-bit match
// - Code breakpoint halts on 10-bit match
// - Base flag set by instructions, host writable
// - Host program/run select acts like switch
`ifndef CCDC_DEFINES_SVH
`define CCDC_DEFINES_SVH

`define CCDC_OFF_CMD      8'h00
`define CCDC_OFF_STATE    8'h04
`define CCDC_OFF_CTRL     8'h08
`define CCDC_OFF_BP_ADDR  8'h0c
`define CCDC_OFF_BP_CODE  8'h10
`define CCDC_OFF_FILL     8'h14
`define CCDC_OFF_CYCLES   8'h18
`define CCDC_OFF_PC       8'h1c
`define CCDC_OFF_REG_IDX  8'h20
`define CCDC_OFF_MODE     8'h24
`define CCDC_OFF_REG_DATA 8'h28
`define CCDC_OFF_IRQ_STAT 8'h2c
`define CCDC_OFF_IRQ_MASK 8'h30
`define CCDC_OFF_OPCODE   8'h34

`define CCDC_CMD_STOP  0
`define CCDC_CMD_RUN   1
`define CCDC_CMD_ANIM  2
`define CCDC_CMD_RESET 3
`define CCDC_CMD_INIT  4
`define CCDC_CMD_STEP  5
`define CCDC_CMD_OVER  6
`define CCDC_CMD_OUT   7
`define CCDC_CMD_CONT  8

`define CCDC_CTRL_BPA_EN 0
`define CCDC_CTRL_BPC_EN 1
`define CCDC_MODE_PRGM   0
`define CCDC_MODE_BASE   1

`define CCDC_EV_HALT   0
`define CCDC_EV_ADDR   1
`define CCDC_EV_CODE   2
`define CCDC_EV_INIT   3
`define CCDC_EV_REFUSE 4
`define CCDC_EV_ANIM   5
`define CCDC_NEV       6

`define CCDC_FILL_RST  8'hff
`define CCDC_PC_ZERO   12'h000
`define CCDC_MEM_LAST  6'h3f
`define CCDC_INIT_LEN  64

`endif

/* File: ccdc_pkg.sv */
// Purpose: Types of the calculator core debug control.
// Assumes: Nothing beyond the core retire interface.
// Notes:   States are one-hot.
package ccdc_pkg;

  typedef enum logic [7:0] {
    ST_HALT  = 8'h01,
    ST_RUN   = 8'h02,
    ST_ANIM  = 8'h04,
    ST_AWAIT = 8'h08,
    ST_STEP  = 8'h10,
    ST_OVER  = 8'h20,
    ST_OUT   = 8'h40,
    ST_INIT  = 8'h80
  } ccdc_state_t;

  typedef struct packed {
    logic        valid;
    logic [9:0]  opcode;
    logic [11:0] next_pc;
    logic        is_call;
    logic        is_ret;
    logic        is_bin;
    logic        is_dec;
  } ccdc_retire_t;

  typedef struct packed {
    logic [3:0]  idx;
    logic [31:0] data;
  } ccdc_regwr_t;

  typedef struct packed {
    logic        we;
    logic [5:0]  addr;
    logic [55:0] wdata;
  } ccdc_mem_t;

endpackage

/* File: ccdc_cmem.sv */
// Purpose: Continuous memory, 64 words of 56 bits.
// Assumes: One write or read per cycle.
// Notes:   Read data registered.
`timescale 1ns/1ns
module ccdc_cmem
  import ccdc_pkg::*;
(
  input  logic        clk,
  input  logic        rst_n,
  input  ccdc_mem_t   port,
  output logic [55:0] rdata
);
  logic [55:0] mem [0:63];
  logic [55:0] next_rdata;

  always_comb begin
    next_rdata = mem[port.addr];
  end

  always_ff @(posedge clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 56'h0;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule

/* File: ccdc_top.sv */
// Purpose: Debug control of a calculator core, reached over APB.
// Assumes: Core executes while core_run is high, reports each retired instruction.
// Notes:   APB answers with one wait state; unmapped addresses give pslverr.
`timescale 1ns/1ns
`include "ccdc_defines.svh"
module ccdc_top
  import ccdc_pkg::*;
(
  input  logic         mclk,
  input  logic         rstn,
  input  logic [7:0]   paddr,
  input  logic         psel,
  input  logic         penable,
  input  logic         pwrite,
  input  logic [31:0]  pwdata,
  output logic [31:0]  prdata,
  output logic         pready,
  output logic         pslverr,
  input  logic [11:0]  core_pc,
  input  logic         core_cur_is_call,
  input  ccdc_retire_t retire,
  input  ccdc_mem_t    core_mem,
  input  logic         prgm_switch,
  output logic         core_run,
  output logic         pc_load,
  output logic [11:0]  pc_load_value,
  output logic         reg_wr,
  output ccdc_regwr_t  reg_wr_info,
  output logic         arith_binary,
  output logic         prgm_mode,
  output logic [55:0]  mem_rdata,
  output logic         irq
);
  logic                 rst_s1;
  logic                 rst_n;
  logic                 sw_s1;
  logic                 sw_s2;
  logic                 sw_s3;
  ccdc_state_t          state;
  ccdc_state_t          next_state;
  logic [1:0]           ctrl;
  logic [1:0]           next_ctrl;
  logic [11:0]          bp_addr;
  logic [11:0]          next_bp_addr;
  logic [9:0]           bp_code;
  logic [9:0]           next_bp_code;
  logic [7:0]           fill;
  logic [7:0]           next_fill;
  logic [15:0]          cycles;
  logic [15:0]          next_cycles;
  logic [7:0]           depth;
  logic [7:0]           next_depth;
  logic [5:0]           init_addr;
  logic [5:0]           next_init_addr;
  logic [3:0]           reg_idx;
  logic [3:0]           next_reg_idx;
  logic [9:0]           last_op;
  logic [9:0]           next_last_op;
  logic [`CCDC_NEV-1:0] status;
  logic [`CCDC_NEV-1:0] next_status;
  logic [`CCDC_NEV-1:0] mask;
  logic [`CCDC_NEV-1:0] next_mask;
  logic [`CCDC_NEV-1:0] ev;
  logic                 next_core_run;
  logic                 next_pc_load;
  logic [11:0]          next_pc_load_value;
  logic                 next_reg_wr;
  ccdc_regwr_t          next_reg_wr_info;
  logic                 next_arith_binary;
  logic                 next_prgm_mode;
  logic                 next_irq;
  logic [31:0]          next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;
  logic                 wr_take;
  logic [8:0]           cmd;
  logic                 halted;
  logic                 busy;
  logic                 done;
  logic                 hit_a;
  logic                 hit_c;
  logic                 exec_run;
  logic [1:0]           exec_state;
  ccdc_mem_t            mem_port;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sw_s1 <= 1'b0;
      sw_s2 <= 1'b0;
      sw_s3 <= 1'b0;
    end else begin
      sw_s1 <= prgm_switch;
      sw_s2 <= sw_s1;
      sw_s3 <= sw_s2;
    end
  end

  assign wr_take  = psel & penable & pwrite & pready;
  assign cmd      = (wr_take && paddr == `CCDC_OFF_CMD) ? pwdata[8:0] : 9'h000;
  assign halted   = (state == ST_HALT);
  assign busy     = (state == ST_RUN) || (state == ST_ANIM) || (state == ST_OVER) || (state == ST_OUT);
  assign exec_run = busy || (state == ST_STEP);
  assign done     = retire.valid & core_run;
  assign hit_a    = ctrl[`CCDC_CTRL_BPA_EN] && retire.next_pc == bp_addr;
  assign hit_c    = ctrl[`CCDC_CTRL_BPC_EN] && retire.opcode == bp_code;
  assign exec_state = (state == ST_ANIM || state == ST_AWAIT) ? 2'h2 : (exec_run ? 2'h1 : 2'h0);

  // Execution control and host side effects
  always_comb begin
    next_state         = state;
    next_ctrl          = ctrl;
    next_bp_addr       = bp_addr;
    next_bp_code       = bp_code;
    next_fill          = fill;
    next_cycles        = cycles;
    next_depth         = depth;
    next_init_addr     = init_addr;
    next_reg_idx       = reg_idx;
    next_last_op       = last_op;
    next_mask          = mask;
    next_pc_load       = 1'b0;
    next_pc_load_value = pc_load_value;
    next_reg_wr        = 1'b0;
    next_reg_wr_info   = reg_wr_info;
    next_arith_binary  = arith_binary;
    next_prgm_mode     = prgm_mode;
    ev                 = '0;
    if (done) begin
      next_cycles  = cycles + 16'h0001;
      next_last_op = retire.opcode;
      if (retire.is_bin) begin
        next_arith_binary = 1'b1;
      end else if (retire.is_dec) begin
        next_arith_binary = 1'b0;
      end
    end
    case (state)
      ST_HALT: begin
        if (cmd[`CCDC_CMD_RUN]) begin
          next_state = ST_RUN;
        end else if (cmd[`CCDC_CMD_ANIM]) begin
          next_state = ST_ANIM;
        end else if (cmd[`CCDC_CMD_STEP]) begin
          next_state = ST_STEP;
        end else if (cmd[`CCDC_CMD_OVER]) begin
          next_state  = core_cur_is_call ? ST_OVER : ST_STEP;
          next_cycles = 16'h0000;
          next_depth  = 8'h00;
        end else if (cmd[`CCDC_CMD_OUT]) begin
          next_state  = ST_OUT;
          next_cycles = 16'h0000;
          next_depth  = 8'h01;
        end else if (cmd[`CCDC_CMD_INIT]) begin
          next_state     = ST_INIT;
          next_init_addr = 6'h00;
        end
      end
      ST_RUN, ST_ANIM, ST_OVER, ST_OUT: begin
        if (done) begin
          if (state == ST_ANIM) begin
            next_state = ST_AWAIT;
            ev[`CCDC_EV_ANIM] = 1'b1;
          end
          if (state == ST_OVER || state == ST_OUT) begin
            if (retire.is_call) begin
              next_depth = depth + 8'h01;
            end else if (retire.is_ret) begin
              next_depth = depth - 8'h01;
              if (depth == 8'h01) begin
                next_state = ST_HALT;
              end
            end
          end
          if (hit_a) begin
            next_state = ST_HALT;
            ev[`CCDC_EV_ADDR] = 1'b1;
          end
          if (hit_c) begin
            next_state = ST_HALT;
            ev[`CCDC_EV_CODE] = 1'b1;
          end
        end
      end
      ST_AWAIT: begin
        if (cmd[`CCDC_CMD_CONT]) begin
          next_state = ST_ANIM;
        end
      end
      ST_STEP: begin
        if (done) begin
          next_state = ST_HALT;
        end
      end
      ST_INIT: begin
        next_init_addr = init_addr + 6'h01;
        if (init_addr == `CCDC_MEM_LAST) begin
          next_state = ST_HALT;
          ev[`CCDC_EV_INIT] = 1'b1;
        end
      end
      default: begin
        next_state = ST_HALT;
      end
    endcase
    if (state != ST_INIT && cmd[`CCDC_CMD_STOP]) begin
      next_state = ST_HALT;
    end
    if (state != ST_INIT && cmd[`CCDC_CMD_RESET]) begin
      next_state         = ST_HALT;
      next_pc_load       = 1'b1;
      next_pc_load_value = `CCDC_PC_ZERO;
    end
    if (state != ST_HALT && next_state == ST_HALT) begin
      ev[`CCDC_EV_HALT] = 1'b1;
    end
    if (sw_s2 != sw_s3) begin
      next_prgm_mode = sw_s2;
    end
    if (wr_take) begin
      case (paddr)
        `CCDC_OFF_CTRL:     next_ctrl    = pwdata[1:0];
        `CCDC_OFF_BP_ADDR:  next_bp_addr = pwdata[11:0];
        `CCDC_OFF_BP_CODE:  next_bp_code = pwdata[9:0];
        `CCDC_OFF_FILL:     next_fill    = pwdata[7:0];
        `CCDC_OFF_REG_IDX:  next_reg_idx = pwdata[3:0];
        `CCDC_OFF_IRQ_MASK: next_mask    = pwdata[`CCDC_NEV-1:0];
        `CCDC_OFF_MODE: begin
          next_prgm_mode = pwdata[`CCDC_MODE_PRGM];
          if (halted) begin
            next_arith_binary = pwdata[`CCDC_MODE_BASE];
          end else begin
            ev[`CCDC_EV_REFUSE] = 1'b1;
          end
        end
        `CCDC_OFF_PC: begin
          if (halted) begin
            next_pc_load       = 1'b1;
            next_pc_load_value = pwdata[11:0];
          end else begin
            ev[`CCDC_EV_REFUSE] = 1'b1;
          end
        end
        `CCDC_OFF_REG_DATA: begin
          if (halted) begin
            next_reg_wr      = 1'b1;
            next_reg_wr_info = '{idx: reg_idx, data: pwdata};
          end else begin
            ev[`CCDC_EV_REFUSE] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    next_core_run = (next_state == ST_RUN) || (next_state == ST_ANIM) || (next_state == ST_STEP) ||
                    (next_state == ST_OVER) || (next_state == ST_OUT);
    next_status = status | ev;
    if (wr_take && paddr == `CCDC_OFF_IRQ_STAT) begin
      next_status = (status & ~pwdata[`CCDC_NEV-1:0]) | ev;
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= ST_HALT;
      ctrl          <= 2'h0;
      bp_addr       <= 12'h000;
      bp_code       <= 10'h000;
      fill          <= `CCDC_FILL_RST;
      cycles        <= 16'h0000;
      depth         <= 8'h00;
      init_addr     <= 6'h00;
      reg_idx       <= 4'h0;
      last_op       <= 10'h000;
      status        <= '0;
      mask          <= '0;
      core_run      <= 1'b0;
      pc_load       <= 1'b0;
      pc_load_value <= 12'h000;
      reg_wr        <= 1'b0;
      reg_wr_info   <= '0;
      arith_binary  <= 1'b0;
      prgm_mode     <= 1'b0;
      irq           <= 1'b0;
    end else begin
      state         <= next_state;
      ctrl          <= next_ctrl;
      bp_addr       <= next_bp_addr;
      bp_code       <= next_bp_code;
      fill          <= next_fill;
      cycles        <= next_cycles;
      depth         <= next_depth;
      init_addr     <= next_init_addr;
      reg_idx       <= next_reg_idx;
      last_op       <= next_last_op;
      status        <= next_status;
      mask          <= next_mask;
      core_run      <= next_core_run;
      pc_load       <= next_pc_load;
      pc_load_value <= next_pc_load_value;
      reg_wr        <= next_reg_wr;
      reg_wr_info   <= next_reg_wr_info;
      arith_binary  <= next_arith_binary;
      prgm_mode     <= next_prgm_mode;
      irq           <= next_irq;
    end
  end

  // APB read path, answer one cycle into the access phase
  always_comb begin
    next_pready  = psel & penable & ~pready;
    next_prdata  = 32'h0;
    next_pslverr = 1'b0;
    case (paddr)
      `CCDC_OFF_CMD:      next_prdata = 32'h0;
      `CCDC_OFF_STATE:    next_prdata = {27'h0, state == ST_INIT, arith_binary, prgm_mode, exec_state};
      `CCDC_OFF_CTRL:     next_prdata = {30'h0, ctrl};
      `CCDC_OFF_BP_ADDR:  next_prdata = {20'h0, bp_addr};
      `CCDC_OFF_BP_CODE:  next_prdata = {22'h0, bp_code};
      `CCDC_OFF_FILL:     next_prdata = {24'h0, fill};
      `CCDC_OFF_CYCLES:   next_prdata = {16'h0, cycles};
      `CCDC_OFF_PC:       next_prdata = {20'h0, core_pc};
      `CCDC_OFF_REG_IDX:  next_prdata = {28'h0, reg_idx};
      `CCDC_OFF_MODE:     next_prdata = {30'h0, arith_binary, prgm_mode};
      `CCDC_OFF_REG_DATA: next_prdata = 32'h0;
      `CCDC_OFF_IRQ_STAT: next_prdata = {26'h0, status};
      `CCDC_OFF_IRQ_MASK: next_prdata = {26'h0, mask};
      `CCDC_OFF_OPCODE:   next_prdata = {22'h0, last_op};
      default:            next_pslverr = next_pready;
    endcase
    if (pwrite || !next_pready) begin
      next_prdata = 32'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Fill sequencer owns the memory during init
  assign mem_port = (state == ST_INIT) ? '{we: 1'b1, addr: init_addr, wdata: {7{fill}}} : core_mem;

  ccdc_cmem u_cmem (
    .clk   (mclk),
    .rst_n (rst_n),
    .port  (mem_port),
    .rdata (mem_rdata)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_onehot;
    $onehot(state);
  endproperty
  a_onehot: assert property (p_onehot) else $error("state not one-hot");

  property p_regwr_halted;
    reg_wr |-> $past(halted);
  endproperty
  a_regwr_halted: assert property (p_regwr_halted) else $error("register write outside halt");

  property p_run_cont;
    (state == ST_RUN) && $past(state == ST_RUN) |-> core_run;
  endproperty
  a_run_cont: assert property (p_run_cont) else $error("run state without core_run");

  property p_anim_pause;
    (state == ST_ANIM) && done && !hit_a && !hit_c && cmd == 9'h000 |=> (state == ST_AWAIT) && !core_run;
  endproperty
  a_anim_pause: assert property (p_anim_pause) else $error("animate did not pause");

  property p_reset;
    cmd[`CCDC_CMD_RESET] && state != ST_INIT |=> halted && pc_load && pc_load_value == 12'h000 ##1 !core_run;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not halt at zero");

  property p_init;
    halted && cmd == 9'h010 |=> (state == ST_INIT) && init_addr == 6'h00 ##63 init_addr == 6'h3f ##1 halted;
  endproperty
  a_init: assert property (p_init) else $error("memory init length wrong");

  property p_step;
    (state == ST_STEP) && done |=> halted ##1 !core_run;
  endproperty
  a_step: assert property (p_step) else $error("single step did not halt");

  property p_over;
    halted && cmd == 9'h040 && core_cur_is_call |=> (state == ST_OVER) && cycles == 16'h0000 && depth == 8'h00;
  endproperty
  a_over: assert property (p_over) else $error("step over start wrong");

  property p_out;
    halted && cmd == 9'h080 |=> (state == ST_OUT) && cycles == 16'h0000 && depth == 8'h01;
  endproperty
  a_out: assert property (p_out) else $error("step out start wrong");

  property p_bp;
    busy && done && (hit_a || hit_c) |=> halted && (status[`CCDC_EV_ADDR] || status[`CCDC_EV_CODE]);
  endproperty
  a_bp: assert property (p_bp) else $error("breakpoint did not halt");

  property p_base;
    done && retire.is_bin && !wr_take |=> arith_binary;
  endproperty
  a_base: assert property (p_base) else $error("binary flag not set");

  property p_halt_still;
    halted && next_state == ST_HALT |=> !core_run;
  endproperty
  a_halt_still: assert property (p_halt_still) else $error("core runs while halted");

  c_bp_hit: cover property (busy && done && hit_a ##1 halted);
  c_over_done: cover property ((state == ST_OVER) && done && retire.is_ret ##1 halted);
  c_init_done: cover property ((state == ST_INIT) ##1 status[`CCDC_EV_INIT]);
  c_anim: cover property ((state == ST_AWAIT) ##[1:20] (state == ST_ANIM));
endmodule

/* File: ccdc_core_model.sv */
// Purpose: Behavioural calculator core facing the debug control.
// Assumes: Fixed program: call at 1 to 8, return at 9 to 2, binary at 3, decimal at 4.
// Notes:   slow leaves an idle cycle after each instruction.
`timescale 1ns/1ns
module ccdc_core_model
  import ccdc_pkg::*;
(
  input  logic         clk,
  input  logic         rst_n,
  input  logic         slow,
  input  logic         core_run,
  input  logic         pc_load,
  input  logic [11:0]  pc_load_value,
  output logic [11:0]  core_pc,
  output logic         core_cur_is_call,
  output ccdc_retire_t retire
);
  logic        gap;
  logic        next_gap;
  logic [11:0] next_pc;

  always_comb begin
    retire           = '0;
    retire.valid     = core_run && !gap;
    retire.opcode    = core_pc[9:0] ^ 10'h2aa;
    retire.is_call   = core_pc == 12'h001;
    retire.is_ret    = core_pc == 12'h009;
    retire.is_bin    = core_pc == 12'h003;
    retire.is_dec    = core_pc == 12'h004;
    retire.next_pc   = retire.is_call ? 12'h008 : retire.is_ret ? 12'h002 : core_pc + 12'h001;
    core_cur_is_call = retire.is_call;
    next_gap         = slow && retire.valid;
    next_pc          = pc_load ? pc_load_value : retire.valid ? retire.next_pc : core_pc;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_pc <= 12'h000;
      gap     <= 1'b0;
    end else begin
      core_pc <= next_pc;
      gap     <= next_gap;
    end
  end
endmodule

/* File: ccdc_top_test.sv */
// Purpose: Self-checking bench of the calculator core debug control.
// Assumes: APB answer order equals request order.
// Notes:   Read expectations are queued and checked on pready.
`timescale 1ns/1ns
`include "ccdc_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module ccdc_top_test;
  import ccdc_pkg::*;
  logic         mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic         prgm_switch = 0, slow = 0;
  logic [7:0]   paddr = 0, f;
  logic [31:0]  pwdata = 0, prdata, w;
  logic         pready, pslverr, core_cur_is_call, core_run, pc_load, reg_wr;
  logic         arith_binary, prgm_mode, irq;
  logic [11:0]  core_pc, pc_load_value, v;
  logic [5:0]   a;
  logic [55:0]  mem_rdata;
  ccdc_retire_t retire;
  ccdc_mem_t    core_mem = '0;
  ccdc_regwr_t  reg_wr_info, reg_seen = '0;
  logic [64:0]  notes[$], n_cur;
  int           miscompares = 0, total_checks = 0;

  ccdc_top ccdc_top_inst (.mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_pc(core_pc), .core_cur_is_call(core_cur_is_call), .retire(retire), .core_mem(core_mem),
    .prgm_switch(prgm_switch), .core_run(core_run), .pc_load(pc_load), .pc_load_value(pc_load_value),
    .reg_wr(reg_wr), .reg_wr_info(reg_wr_info), .arith_binary(arith_binary), .prgm_mode(prgm_mode),
    .mem_rdata(mem_rdata), .irq(irq));
  ccdc_core_model ccdc_core_model_inst (.clk(mclk), .rst_n(rstn), .slow(slow), .core_run(core_run),
    .pc_load(pc_load), .pc_load_value(pc_load_value), .core_pc(core_pc),
    .core_cur_is_call(core_cur_is_call), .retire(retire));

  always #2 mclk = ~mclk;

  always @(posedge mclk) begin
    if (reg_wr === 1'b1) reg_seen <= reg_wr_info;
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      n_cur = notes.pop_front();
      `CHK("pslverr", n_cur[64], pslverr)
      `CHK("prdata", n_cur[31:0], prdata & n_cur[63:32])
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask

  task automatic xfer(input logic [7:0] ad, input logic wr_n, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    notes.push_back({ad > 8'h34, m, wr_n ? 32'h0 : d});
    paddr   <= ad;
    pwrite  <= wr_n;
    pwdata  <= d;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never reassigns psel in this time step
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(ad, 1'b1, d, 32'hffffffff);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    xfer(ad, 1'b0, e & m, m);
  endtask

  task automatic cmd(input int b);
    wr(`CCDC_OFF_CMD, 32'h1 << b);
  endtask

  task automatic hold;
    int n;
    n = 0;
    tick(2);
    while (core_run !== 1'b0 && n < 500) begin
      tick(1);
      n++;
    end
    if (n >= 500) miscompares++;
    tick(1);
  endtask

  task automatic restart;
    cmd(`CCDC_CMD_RESET);
    tick(2);
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    tick(20000);
    miscompares++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(94861));
    f = $urandom;
    a = $urandom;
    v = $urandom;
    w = $urandom;
    tick(6);
    rstn <= 1'b1;
    tick(3);
    rd(`CCDC_OFF_FILL, 32'hff);
    rd(`CCDC_OFF_STATE, 32'h0, 32'h1f);
    rd(8'h3c, 32'h0);
    wr(8'h3c, 32'h0);
    // Host writes while halted
    wr(`CCDC_OFF_PC, {20'h0, v});
    tick(2);
    rd(`CCDC_OFF_PC, {20'h0, v});
    wr(`CCDC_OFF_REG_IDX, 32'h5);
    wr(`CCDC_OFF_REG_DATA, w);
    tick(3);
    `CHK("reg_wr_info", {4'h5, w}, reg_seen)
    restart;
    rd(`CCDC_OFF_PC, 32'h0);
    cmd(`CCDC_CMD_STEP);
    hold;
    rd(`CCDC_OFF_PC, 32'h1);
    tick(10);
    rd(`CCDC_OFF_PC, 32'h1);
    // Step over a call with a slow core, then at a plain instruction
    slow <= 1'b1;
    cmd(`CCDC_CMD_OVER);
    hold;
    rd(`CCDC_OFF_PC, 32'h2);
    rd(`CCDC_OFF_CYCLES, 32'h3, 32'hffff);
    slow <= 1'b0;
    cmd(`CCDC_CMD_OVER);
    hold;
    rd(`CCDC_OFF_PC, 32'h3);
    restart;
    cmd(`CCDC_CMD_STEP);
    hold;
    cmd(`CCDC_CMD_STEP);
    hold;
    cmd(`CCDC_CMD_OUT);
    hold;
    rd(`CCDC_OFF_PC, 32'h2);
    rd(`CCDC_OFF_CYCLES, 32'h2, 32'hffff);
    // Address breakpoint right after the binary instruction
    restart;
    wr(`CCDC_OFF_BP_ADDR, 32'h4);
    wr(`CCDC_OFF_CTRL, 32'h1);
    cmd(`CCDC_CMD_RUN);
    hold;
    rd(`CCDC_OFF_PC, 32'h4);
    rd(`CCDC_OFF_STATE, 32'h8, 32'hb);
    cmd(`CCDC_CMD_STEP);
    hold;
    rd(`CCDC_OFF_STATE, 32'h0, 32'hb);
    wr(`CCDC_OFF_MODE, 32'h2);
    tick(2);
    `CHK("arith_binary", 1'b1, arith_binary)
    restart;
    wr(`CCDC_OFF_CTRL, 32'h2);
    wr(`CCDC_OFF_BP_CODE, 32'h2ac);
    cmd(`CCDC_CMD_RUN);
    hold;
    rd(`CCDC_OFF_PC, 32'h7);
    // Free run, refused write, stop
    wr(`CCDC_OFF_CTRL, 32'h0);
    wr(`CCDC_OFF_IRQ_STAT, 32'h3f);
    cmd(`CCDC_CMD_RUN);
    tick(4);
    `CHK("core_run", 1'b1, core_run)
    rd(`CCDC_OFF_STATE, 32'h1, 32'h3);
    wr(`CCDC_OFF_PC, 32'h123);
    rd(`CCDC_OFF_IRQ_STAT, 32'h10, 32'h10);
    cmd(`CCDC_CMD_STOP);
    hold;
    rd(`CCDC_OFF_STATE, 32'h0, 32'h3);
    restart;
    cmd(`CCDC_CMD_ANIM);
    hold;
    rd(`CCDC_OFF_PC, 32'h1);
    rd(`CCDC_OFF_STATE, 32'h2, 32'h3);
    rd(`CCDC_OFF_IRQ_STAT, 32'h20, 32'h20);
    cmd(`CCDC_CMD_CONT);
    hold;
    rd(`CCDC_OFF_PC, 32'h8);
    cmd(`CCDC_CMD_STOP);
    tick(2);
    // Interrupt raised, masked, cleared
    wr(`CCDC_OFF_IRQ_STAT, 32'h3f);
    wr(`CCDC_OFF_IRQ_MASK, 32'h1);
    cmd(`CCDC_CMD_STEP);
    hold;
    tick(2);
    `CHK("irq", 1'b1, irq)
    wr(`CCDC_OFF_IRQ_MASK, 32'h0);
    tick(2);
    `CHK("irq", 1'b0, irq)
    wr(`CCDC_OFF_IRQ_MASK, 32'h1);
    tick(2);
    `CHK("irq", 1'b1, irq)
    wr(`CCDC_OFF_IRQ_STAT, 32'h1);
    tick(2);
    `CHK("irq", 1'b0, irq)
    // Slider and host mode select
    prgm_switch <= 1'b1;
    tick(5);
    `CHK("prgm_mode", 1'b1, prgm_mode)
    rd(`CCDC_OFF_STATE, 32'h4, 32'h4);
    wr(`CCDC_OFF_MODE, 32'h0);
    tick(2);
    `CHK("prgm_mode", 1'b0, prgm_mode)
    // Memory fill
    wr(`CCDC_OFF_FILL, {24'h0, f});
    core_mem <= {1'b0, a, 56'h0};
    cmd(`CCDC_CMD_INIT);
    tick(70);
    rd(`CCDC_OFF_IRQ_STAT, 32'h8, 32'h8);
    rd(`CCDC_OFF_STATE, 32'h0, 32'h10);
    `CHK("mem_rdata", {7{f}}, mem_rdata)
    tally_and_finish;
  end
endmodule
